/* File: core/asp_defines.svh */
// Offsets, field positions, reset values and timing counts of the serial register port
// Function
// - Every transaction starts with a command write; after reset a command is expected.
// - The command byte selects read or write and the target register.
// - Data enters on the input line, leaves on the output line, timed by serial clock.
// - Ready output goes low when a new result word is available.
// - Ready output returns high once a serial result read completes.
// - Ready output goes high before the result register is updated.
// - The same result may be read again; host finishes before the next update.
// - Active-low select enables the port so several devices share one bus.
// - With select tied low, ready status reads as command register MSB.
// - Select falling edge presents the first output bit in frame-sync use.
// - Serial clocks while not selected are ignored.
// - The reset input returns the port to waiting for a command write.
// - Input held one for 32 serial clocks resynchronises the port.
// - The ones-sequence reset leaves every register unchanged.
// - Six registers, all reached through a command write.
// - Registers are 8 bits, result 16 bits, offset and gain 24 bits.
// - Wider registers transfer as consecutive 8-bit serial transfers.
// - After the eighth command clock the selected operation starts at once.
// - Half duplex: nothing driven during writes, input ignored during reads; the code still counts input ones there for the 32-clock reset.
// - Words travel most significant bit first both ways.
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH
`define ASP_ADDR_RESULT 12'h000
`define ASP_ADDR_STATUS 12'h004
`define ASP_ST_READY 0
`define ASP_ST_STATE 1
`define ASP_ST_SEL 3
`define ASP_ST_ONES 6
`define ASP_ST_UPD 12
`define ASP_CMD_RD_BIT 3
`define ASP_CMD_SEL_LSB 4
`define ASP_CMD_READY_BIT 7
`define ASP_CMD_RST 8'h00
`define ASP_REG_COMM 3'h0
`define ASP_REG_SETUP 3'h1
`define ASP_REG_CLOCK 3'h2
`define ASP_REG_DATA 3'h3
`define ASP_REG_OFFSET 3'h4
`define ASP_REG_GAIN 3'h5
`define ASP_NUM_REGS 6
`define ASP_ONES_MIN 6'h20
`define ASP_CLK_NS 5
`define ASP_UPD_LEAD_NS 100
`define ASP_UPD_LEAD_CYC ((`ASP_UPD_LEAD_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
`endif

/* File: core/asp_pkg.sv */
// Types of the serial register port
package asp_pkg;
   typedef enum logic [1:0] {
      ASP_ST_CMD = 2'h0,
      ASP_ST_WR = 2'h1,
      ASP_ST_RD = 2'h3
   } asp_state_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } asp_apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } asp_apb_rsp_s;

   typedef struct packed {
      logic sclk;
      logic din;
      logic cs_n;
      logic port_rst_n;
   } asp_pins_s;

   typedef struct packed {
      logic [2:0] sck_q;
      logic [1:0] din_q;
      logic [2:0] cs_q;
      logic [1:0] prst_q;
      asp_state_e state;
      logic [2:0] bitcnt;
      logic [1:0] bytecnt;
      logic first;
      logic [2:0] sel;
      logic [7:0] cmd;
      logic [23:0] sin;
      logic [23:0] sout;
      logic dout;
      logic oe;
      logic [5:0] ones;
      logic we;
      logic [2:0] wa;
      logic [23:0] wd;
      logic [15:0] result;
      logic [15:0] pend;
      logic upd;
      logic [7:0] lead;
      logic ready_n;
      logic [31:0] prdata;
   } asp_core_s;
endpackage : asp_pkg

/* File: core/asp_regfile.sv */
// Register storage with registered read data
`timescale 1ns/1ps
module asp_regfile #(
   parameter int DW = 24,
   parameter int DEPTH = 6,
   parameter int AW = 3
) (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);
   logic [DW-1:0] mem [DEPTH];

   // Out-of-range addresses read zero and drop writes
   always_ff @(posedge clk_i) begin
      if (we_i && (int'(waddr_i) < DEPTH)) begin
         mem[waddr_i] <= wdata_i;
      end
      if (int'(raddr_i) < DEPTH) begin
         rdata_o <= mem[raddr_i];
      end else begin
         rdata_o <= '0;
      end
   end
endmodule : asp_regfile

/* File: core/asp_serial_port.sv */
// Serial register port of the converter with APB access to result and status
`timescale 1ns/1ps
`include "asp_defines.svh"
module asp_serial_port #(
   parameter int UPD_LEAD = `ASP_UPD_LEAD_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire asp_pkg::asp_apb_req_s apb_req_i,
   output asp_pkg::asp_apb_rsp_s apb_rsp_o,
   input wire asp_pkg::asp_pins_s pins_i,
   output logic dout_o,
   output logic dout_oe_o,
   output logic result_ready_n_o
);
   asp_pkg::asp_core_s s;
   asp_pkg::asp_core_s n;
   logic [1:0] rst_q;
   logic rst_n;
   logic [23:0] rf_rdata;

   // Bytes carried by each register
   function automatic logic [1:0] reg_bytes(input logic [2:0] sel);
      case (sel)
         `ASP_REG_DATA: reg_bytes = 2'h2;
         `ASP_REG_OFFSET, `ASP_REG_GAIN: reg_bytes = 2'h3;
         default: reg_bytes = 2'h1;
      endcase
   endfunction : reg_bytes

   // Registers that host writes may change
   function automatic logic writable(input logic [2:0] sel);
      writable = (sel == `ASP_REG_SETUP) || (sel == `ASP_REG_CLOCK) ||
                 (sel == `ASP_REG_OFFSET) || (sel == `ASP_REG_GAIN);
   endfunction : writable

   // Reset release through two flops
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   asp_regfile #(
      .DW(24),
      .DEPTH(`ASP_NUM_REGS),
      .AW(3)
   ) u_regs (
      .clk_i(core_clk_i),
      .we_i(s.we),
      .waddr_i(s.wa),
      .wdata_i(s.wd),
      .raddr_i(s.sel),
      .rdata_o(rf_rdata)
   );

   logic sck_rise;
   logic sck_fall;
   logic selected;
   logic cs_fall;
   logic din;
   logic port_rst;
   logic last_byte;
   logic [7:0] in_byte;
   logic [23:0] rd_val;
   logic [23:0] rd_aligned;
   logic [5:0] ones_inc;
   logic apb_setup;
   logic apb_access;
   logic addr_ok;

   always_comb begin
      // Edges are found on the synchronised copies only
      sck_rise = s.sck_q[1] & ~s.sck_q[2];
      sck_fall = ~s.sck_q[1] & s.sck_q[2];
      selected = ~s.cs_q[1];
      cs_fall = ~s.cs_q[1] & s.cs_q[2];
      din = s.din_q[1];
      port_rst = ~s.prst_q[1];
      last_byte = (s.bytecnt == reg_bytes(s.sel) - 2'h1);
      in_byte = {s.sin[6:0], din};
      ones_inc = s.ones + 6'h01;
      rd_val = 24'h0;
      if (s.sel == `ASP_REG_COMM) begin
         rd_val[7:0] = {s.ready_n, s.cmd[6:0]};
      end else if (s.sel == `ASP_REG_DATA) begin
         rd_val[15:0] = s.result;
      end else begin
         rd_val = rf_rdata;
      end
      // left-justify so the MSB leaves first
      case (reg_bytes(s.sel))
         2'h2: rd_aligned = {rd_val[15:0], 8'h00};
         2'h3: rd_aligned = rd_val;
         default: rd_aligned = {rd_val[7:0], 16'h0000};
      endcase
      apb_setup = apb_req_i.psel & ~apb_req_i.penable;
      apb_access = apb_req_i.psel & apb_req_i.penable;
      addr_ok = (apb_req_i.paddr == `ASP_ADDR_RESULT) ||
                (apb_req_i.paddr == `ASP_ADDR_STATUS);
   end

   always_comb begin
      n = s;
      n.sck_q = {s.sck_q[1:0], pins_i.sclk};
      n.din_q = {s.din_q[0], pins_i.din};
      n.cs_q = {s.cs_q[1:0], pins_i.cs_n};
      n.prst_q = {s.prst_q[0], pins_i.port_rst_n};
      n.we = 1'b0;

      if (port_rst) begin
         // pin reset back to command wait
         n.state = asp_pkg::ASP_ST_CMD;
         n.bitcnt = 3'h0;
         n.bytecnt = 2'h0;
         n.ones = 6'h00;
         n.oe = 1'b0;
         n.first = 1'b0;
      end else if (selected && sck_rise) begin
         n.ones = din ? ones_inc : 6'h00;
         n.sin = {s.sin[22:0], din};
         n.bitcnt = s.bitcnt + 3'h1;
         if (din && (ones_inc >= `ASP_ONES_MIN)) begin
            n.state = asp_pkg::ASP_ST_CMD;
            n.bitcnt = 3'h0;
            n.bytecnt = 2'h0;
            n.ones = 6'h00;
            n.oe = 1'b0;
            n.first = 1'b0;
         end else begin
            unique case (s.state)
               asp_pkg::ASP_ST_CMD: begin
                  if (s.bitcnt == 3'h7) begin
                     n.cmd = in_byte;
                     n.sel = in_byte[`ASP_CMD_SEL_LSB +: 3];
                     n.bytecnt = 2'h0;
                     if (in_byte[`ASP_CMD_RD_BIT]) begin
                        n.state = asp_pkg::ASP_ST_RD;
                        n.first = 1'b1;
                     end else begin
                        n.state = asp_pkg::ASP_ST_WR;
                     end
                  end
               end
               asp_pkg::ASP_ST_WR: begin
                  // data taken from the input line
                  if (s.bitcnt == 3'h7) begin
                     if (last_byte) begin
                        n.we = writable(s.sel);
                        n.wa = s.sel;
                        n.wd = {s.sin[22:0], din};
                        n.state = asp_pkg::ASP_ST_CMD;
                        n.bytecnt = 2'h0;
                     end else begin
                        n.bytecnt = s.bytecnt + 2'h1;
                     end
                  end
               end
               asp_pkg::ASP_ST_RD: begin
                  if (s.bitcnt == 3'h7) begin
                     if (last_byte) begin
                        n.state = asp_pkg::ASP_ST_CMD;
                        n.bytecnt = 2'h0;
                        n.oe = 1'b0;
                        if (s.sel == `ASP_REG_DATA) begin
                           n.ready_n = 1'b1;
                        end
                     end else begin
                        n.bytecnt = s.bytecnt + 2'h1;
                     end
                  end
               end
               default: begin
                  n.state = asp_pkg::ASP_ST_CMD;
                  n.bitcnt = 3'h0;
               end
            endcase
         end
      end else if (selected && (s.state == asp_pkg::ASP_ST_RD) &&
                   ((s.first && cs_fall) || sck_fall)) begin
         if (s.first) begin
            n.sout = {rd_aligned[22:0], 1'b0};
            n.dout = rd_aligned[23];
            n.first = 1'b0;
            n.oe = 1'b1;
         end else begin
            n.sout = {s.sout[22:0], 1'b0};
            n.dout = s.sout[23];
         end
      end

      // ready high ahead of the update
      if (apb_access && apb_req_i.pwrite &&
          (apb_req_i.paddr == `ASP_ADDR_RESULT)) begin
         n.pend = apb_req_i.pwdata[15:0];
         n.ready_n = 1'b1;
         n.upd = 1'b1;
         n.lead = 8'(UPD_LEAD);
      end else if (s.upd) begin
         if (s.lead <= 8'h01) begin
            n.result = s.pend;
            n.ready_n = 1'b0;
            n.upd = 1'b0;
            n.lead = 8'h00;
         end else begin
            n.lead = s.lead - 8'h01;
         end
      end

      // Read data is latched in the setup cycle for a zero-wait answer
      if (apb_setup) begin
         n.prdata = 32'h0;
         if (apb_req_i.paddr == `ASP_ADDR_RESULT) begin
            n.prdata[15:0] = s.result;
         end else if (apb_req_i.paddr == `ASP_ADDR_STATUS) begin
            n.prdata[`ASP_ST_READY] = s.ready_n;
            n.prdata[`ASP_ST_STATE +: 2] = s.state;
            n.prdata[`ASP_ST_SEL +: 3] = s.sel;
            n.prdata[`ASP_ST_ONES +: 6] = s.ones;
            n.prdata[`ASP_ST_UPD] = s.upd;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.sck_q <= 3'h7;
         s.cs_q <= 3'h7;
         s.prst_q <= 2'h3;
         s.state <= asp_pkg::ASP_ST_CMD;
         s.cmd <= `ASP_CMD_RST;
         s.ready_n <= 1'b1;
      end else begin
         s <= n;
      end
   end

   always_comb begin
      apb_rsp_o.pready = 1'b1;
      apb_rsp_o.pslverr = apb_access & ~addr_ok;
      apb_rsp_o.prdata = s.prdata;
   end

   assign dout_oe_o = s.oe & ~s.cs_q[1];
   assign dout_o = s.dout;
   assign result_ready_n_o = s.ready_n;
endmodule : asp_serial_port

/* File: testbench/asp_host.sv */
// Serial host model: framed transfers and port reset pulse
`timescale 1ns/1ps
module asp_host (
   input wire logic dout_i,
   input wire logic oe_i,
   output asp_pkg::asp_pins_s pins_o
);
   logic last;
   initial begin
      pins_o = '{sclk: 1'b1, din: 1'b0, cs_n: 1'b1, port_rst_n: 1'b1};
      last = 1'b0;
   end
   task automatic frame(input logic [39:0] tx, input int n, input logic sel, output logic [31:0] rx);
      rx = '0;
      for (int i = 0; i < n; i++) begin
         pins_o.sclk <= 1'b0;
         #4;
         pins_o.cs_n <= !sel;
         pins_o.din <= tx[39-i];
         #(i == 0 ? 32 : 28);
         // Released line shows the inverse, never a stale bit
         last = oe_i ? dout_i : !last;
         rx = {rx[30:0], last};
         pins_o.sclk <= 1'b1;
         #32;
      end
      pins_o.cs_n <= 1'b1;
      #32;
   endtask : frame
   task automatic pulse_rst();
      pins_o.port_rst_n <= 1'b0;
      #50;
      pins_o.port_rst_n <= 1'b1;
      #50;
   endtask : pulse_rst
endmodule : asp_host

/* File: testbench/asp_port_chk.sv */
// Assertion checker of the serial register port, bound to its top module
`timescale 1ns/1ps
module asp_port_chk #(
   parameter int UPD_LEAD = 20
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire asp_pkg::asp_apb_req_s apb_req_i,
   input wire asp_pkg::asp_apb_rsp_s apb_rsp_o,
   input wire asp_pkg::asp_pins_s pins_i,
   input wire logic dout_o,
   input wire logic dout_oe_o,
   input wire logic result_ready_n_o
);
   localparam int LEAD_LO = UPD_LEAD - 1;
   localparam int LEAD_HI = UPD_LEAD + 3;
   logic [5:0] since_wr;
   logic [3:0] since_fall;
   logic [3:0] since_oef;
   logic sclk_q;
   logic cs_q;
   logic oe_q;
   logic acc;
   logic res_wr;
   logic fall;
   assign acc = apb_req_i.psel && apb_req_i.penable;
   assign res_wr = acc && apb_req_i.pwrite && apb_req_i.paddr == 12'h000;
   assign fall = (sclk_q && !pins_i.sclk) || (cs_q && !pins_i.cs_n);
   // Saturating ages of the last result write, serial edge and output release
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         since_wr <= 6'h3f;
         since_fall <= 4'hf;
         since_oef <= 4'hf;
         sclk_q <= 1'b1;
         cs_q <= 1'b1;
         oe_q <= 1'b0;
      end else begin
         sclk_q <= pins_i.sclk;
         cs_q <= pins_i.cs_n;
         oe_q <= dout_oe_o;
         since_wr <= res_wr ? 6'h00 : since_wr + {5'h0, since_wr != 6'h3f};
         since_fall <= fall ? 4'h0 : since_fall + {3'h0, since_fall != 4'hf};
         since_oef <= (oe_q && !dout_oe_o) ? 4'h0 : since_oef + {3'h0, since_oef != 4'hf};
      end
   end
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_ready_hi: assert property (res_wr |=> result_ready_n_o [*2])
      else $error("ready not high after result write");
   a_ready_new: assert property (res_wr |-> ##[LEAD_LO:LEAD_HI] !result_ready_n_o)
      else $error("ready not low after update");
   a_ready_fall: assert property ($fell(result_ready_n_o) |-> since_wr inside {[LEAD_LO:LEAD_HI]})
      else $error("ready fell without update");
   a_ready_rise: assert property ($rose(result_ready_n_o) |->
      (since_wr == 6'h00 || since_oef <= 4'h4) or ##[0:4] $fell(dout_oe_o))
      else $error("ready rose without cause");
   a_oe_desel: assert property (pins_i.cs_n [*4] |-> !dout_oe_o)
      else $error("output driven while deselected");
   a_dout_edge: assert property (dout_oe_o && $past(dout_oe_o) && $changed(dout_o) |-> since_fall <= 4'h8)
      else $error("output changed away from falling edge");
   a_bad_addr: assert property (acc && apb_req_i.paddr != 12'h000 && apb_req_i.paddr != 12'h004
      |-> apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0)
      else $error("unmapped access not refused");
   a_good_addr: assert property (acc && (apb_req_i.paddr == 12'h000 || apb_req_i.paddr == 12'h004)
      |-> !apb_rsp_o.pslverr && apb_rsp_o.pready)
      else $error("mapped access refused");
   a_rst_idle: assert property ($rose(rst_n_i) |-> result_ready_n_o && !dout_oe_o)
      else $error("port not idle after reset");
endmodule : asp_port_chk
bind asp_serial_port asp_port_chk #(.UPD_LEAD(UPD_LEAD)) u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
   .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .pins_i(pins_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
   .result_ready_n_o(result_ready_n_o));

/* File: testbench/tb.sv */
// Self-checking bench of the serial register port
`timescale 1ns/1ps
module tb;
   logic core_clk_i;
   logic rst_n_i;
   asp_pkg::asp_apb_req_s req;
   asp_pkg::asp_apb_rsp_s rsp;
   asp_pkg::asp_pins_s pins;
   logic dout;
   logic oe;
   logic rdy_n;
   logic [31:0] rd;
   logic err;
   logic [31:0] rx;
   int failures;
   int checks;
   // Short lead keeps the update window quick to reach
   asp_serial_port #(.UPD_LEAD(4)) dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .apb_req_i(req),
      .apb_rsp_o(rsp), .pins_i(pins), .dout_o(dout), .dout_oe_o(oe), .result_ready_n_o(rdy_n));
   asp_host host (.dout_i(dout), .oe_i(oe), .pins_o(pins));
   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : compare
   task automatic stop_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk_i);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge core_clk_i);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      @(posedge core_clk_i);
      if (n >= 20) begin
         failures++;
         stop_test();
      end
   endtask : apb
   task automatic wait_rdy(input logic v);
      int n;
      n = 0;
      while (rdy_n !== v && n < 200) begin
         @(posedge core_clk_i);
         n++;
      end
      if (n >= 200) begin
         failures++;
         stop_test();
      end
   endtask : wait_rdy
   task automatic t_reset();
      compare(rdy_n, 1'b1);
      compare(oe, 1'b0);
      apb(1'b0, 12'h004, 32'h0);
      compare(rd[2:0], 3'h1);
      apb(1'b0, 12'h008, 32'h0);
      compare(err, 1'b1);
      compare(rd, 32'h0);
   endtask : t_reset
   task automatic t_regs();
      logic [7:0] cmd [4] = '{8'h10, 8'h20, 8'h40, 8'h50};
      int nb [4] = '{1, 1, 3, 3};
      logic [23:0] dat [4] = '{24'ha50000, 24'h3c0000, 24'h123456, 24'hfedcba};
      for (int i = 0; i < 4; i++) begin
         host.frame({cmd[i], dat[i], 8'h00}, 8 + 8 * nb[i], 1'b1, rx);
      end
      for (int i = 0; i < 4; i++) begin
         host.frame({cmd[i] | 8'h08, 32'h0}, 8 + 8 * nb[i], 1'b1, rx);
         compare(rx & ((32'h1 << (8 * nb[i])) - 32'h1), dat[i] >> (24 - 8 * nb[i]));
      end
      host.frame({8'h08, 32'h0}, 16, 1'b1, rx);
      compare(rx[7:0], 8'h88);
   endtask : t_regs
   task automatic t_result();
      apb(1'b1, 12'h000, 32'hffffa5c3);
      compare(rdy_n, 1'b1);
      wait_rdy(1'b0);
      compare(rdy_n, 1'b0);
      apb(1'b0, 12'h000, 32'h0);
      compare(rd, 32'h0000a5c3);
      host.frame({8'h08, 32'h0}, 16, 1'b1, rx);
      compare(rx[7:0], 8'h08);
      host.frame({8'h38, 32'h0}, 8, 1'b1, rx);
      host.frame(40'h0, 16, 1'b1, rx);
      compare(rx[15:0], 16'ha5c3);
      wait_rdy(1'b1);
      compare(rdy_n, 1'b1);
      host.frame({8'h38, 16'h5555, 16'h0}, 24, 1'b1, rx);
      compare(rx[15:0], 16'ha5c3);
   endtask : t_result
   task automatic t_ones();
      host.frame({8'h48, 32'hffffffff}, 40, 1'b1, rx);
      compare(rx[31:8], 24'h123456);
      apb(1'b0, 12'h004, 32'h0);
      compare(rd[2:1], 2'h0);
      host.frame({8'h48, 32'h0}, 32, 1'b1, rx);
      compare(rx[23:0], 24'h123456);
   endtask : t_ones
   task automatic t_port();
      host.frame({8'h10, 8'h77, 24'h0}, 16, 1'b0, rx);
      host.frame({8'h18, 32'h0}, 16, 1'b1, rx);
      compare(rx[7:0], 8'ha5);
      host.frame({8'h10, 32'h0}, 8, 1'b1, rx);
      apb(1'b0, 12'h004, 32'h0);
      compare(rd[5:1], 5'h05);
      host.pulse_rst();
      apb(1'b0, 12'h004, 32'h0);
      compare(rd[2:1], 2'h0);
      host.frame({8'h18, 32'h0}, 16, 1'b1, rx);
      compare(rx[7:0], 8'ha5);
   endtask : t_port
   initial begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   initial begin
      rst_n_i = 1'b0;
      req = '0;
      failures = 0;
      checks = 0;
      repeat (3) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      t_reset();
      t_regs();
      t_result();
      t_ones();
      t_port();
      stop_test();
   end
endmodule : tb
